// >>> rtl/dpb_pkg.sv
/*
 Constants for the data path and sample buffer block: register indices,
 field positions, reset values, buffer limits and rate timing.
 Assumes a 40 MHz system clock and an APB master with 32-bit data.
*/
// How it works
// - Any flush write empties buffer and level
// - Flush also drops trigger flag unless trigger mode sees a trigger that cycle
// - Flush drops full/watermark flags and interrupt pin
// - Flush and path controls writable while running
// - Output register returns oldest bytes, two's complement
// - Path runs only with engine enable set
// - RMS count code picks 2 to 256 samples
// - Filters at path rate, RMS at rate/count
// - Rate code 0 is 0.781 Hz, doubling each step
// - With routing bit 6 set, motion engines take path rate and RMS count
// - Path input first averaged per low-power count
// - Routing bit 7 picks raw or path buffer data
// - Routing bit 6 picks motion engine input
// - Routing bit 5 sends RMS to motion engines
// - Bits 4 and 3 bypass second, first filter
// - Bit 1 picks filter or RMS path output
// - Bit 0 makes second filter high-pass
// - First filter 1/A is seven bits, bit 7 zero
// - First filter B/A is 23 bits over three bytes
// - Resolution bit picks 8-bit or 16-bit samples
package dpb_pkg;
    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_FLUSH = 8'h62;
    localparam logic [7:0] IDX_OUT = 8'h63;
    localparam logic [7:0] IDX_RATE = 8'h64;
    localparam logic [7:0] IDX_ROUTE = 8'h65;
    localparam logic [7:0] IDX_INVA = 8'h66;
    localparam logic [7:0] IDX_RLOW = 8'h67;
    localparam logic [7:0] IDX_RMID = 8'h68;
    localparam logic [7:0] IDX_RHIGH = 8'h69;
    localparam logic [7:0] IDX_CTRL = 8'h78;
    localparam logic [7:0] IDX_STAT = 8'h79;
    // Reset values
    localparam logic [7:0] ROUTE_RESET = 8'h02;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Writable bits of the routing and coefficient registers
    localparam logic [7:0] ROUTE_WMASK = 8'hFB;
    localparam logic [7:0] TOP0_WMASK = 8'h7F;
    // Routing register fields
    localparam int B_BUF_SRC = 7;
    localparam int B_MOT_IN = 6;
    localparam int B_MOT_RMS = 5;
    localparam int B_F2_BYP = 4;
    localparam int B_F1_BYP = 3;
    localparam int B_OUT_RMS = 1;
    localparam int B_F2_HP = 0;
    // Rate register fields
    localparam int RATE_LSB = 0;
    localparam int RMS_LSB = 4;
    // Own control register fields
    localparam int C_ENG = 0;
    localparam int C_OPER = 1;
    localparam int C_RES = 2;
    localparam int C_MODE_LSB = 3;
    localparam int C_LPAVG_LSB = 5;
    // Own status register fields
    localparam int S_TRIG = 15;
    localparam int S_FULL = 14;
    localparam int S_WMARK = 13;
    // Buffer geometry
    localparam logic [2:0] BYTES_LO = 3'h3;
    localparam logic [2:0] BYTES_HI = 3'h6;
    localparam logic [7:0] SETS_LO = 8'hAB;
    localparam logic [7:0] SETS_HI = 8'h56;
    // Second filter gain, fixed here
    localparam logic [6:0] F2_COEF = 7'h40;
    // Timing: slowest path rate in micro-hertz
    localparam longint CLK_HZ = 40000000;
    localparam longint PATH_MIN_RATE_UHZ = 781250;
    localparam longint PATH_BASE_CYCLES = (CLK_HZ * 64'd1000000) / PATH_MIN_RATE_UHZ;
    // Buffer operating modes
    typedef enum logic [1:0] {BUF_FIFO, BUF_STREAM, BUF_TRIGGER, BUF_BYPASS} dpb_mode_t;
endpackage

// >>> rtl/dpb_top.sv
/*
 Advanced data path with sample buffer: input averaging, two filter
 stages, RMS stage, routing to path outputs, motion engines and buffer,
 plus an APB register slave. Assumes acceleration samples arrive as
 single-cycle strobes from logic on the same clock.
*/
// Chosen here: the APB register port.
`timescale 1ns/10ps
module dpb_top #(
    parameter int unsigned DEPTH = 171, // Buffer sets held
    parameter int unsigned WMARK = 16, // Sets that raise watermark
    parameter longint BASE_CYCLES = dpb_pkg::PATH_BASE_CYCLES // Period at rate code 0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Raw acceleration and events
    input wire logic accel_valid,
    input wire logic signed [15:0] accel_x,
    input wire logic signed [15:0] accel_y,
    input wire logic signed [15:0] accel_z,
    input wire logic trigger_event,
    input wire logic [2:0] wake_rate_field,
    input wire logic [2:0] sleep_rate_field,
    // Path output registers
    output logic path_out_valid,
    output logic signed [15:0] path_x_output,
    output logic signed [15:0] path_y_output,
    output logic signed [15:0] path_z_output,
    // Motion engine feed
    output logic motion_valid,
    output logic signed [15:0] motion_x,
    output logic signed [15:0] motion_y,
    output logic signed [15:0] motion_z,
    output logic [3:0] wake_rate_used,
    output logic [3:0] sleep_rate_used,
    output logic [2:0] motion_avg_count,
    // Latched interrupt pin
    output logic irq_pin
);
    // Software registers
    logic [7:0] rate_r, route_r, inva_r, rlow_r, rmid_r, rhigh_r, ctrl_r;
    // Buffer state
    logic [47:0] mem_r [DEPTH];
    logic [7:0] wr_r, rd_r, cnt_r;
    logic [2:0] bidx_r;
    logic trig_r, full_flag_r, wm_flag_r;
    // Data path state
    logic signed [15:0] raw [3];
    logic signed [23:0] lpacc_r [3];
    logic signed [15:0] avg_r [3], y1_r [3], y2_r [3], filt_r [3];
    logic [15:0] rms_r [3];
    logic [23:0] rmsacc_r [3];
    logic [7:0] lpcnt_r;
    logic [8:0] rmscnt_r;
    logic [25:0] ratecnt_r;
    logic tick_r, filt_v_r, rms_v_r;

    // Field views
    wire eng_run = ctrl_r[dpb_pkg::C_ENG] & ctrl_r[dpb_pkg::C_OPER];
    wire res_hi = ctrl_r[dpb_pkg::C_RES];
    wire [2:0] lpavg = ctrl_r[dpb_pkg::C_LPAVG_LSB +: 3];
    wire [3:0] rate_code = rate_r[dpb_pkg::RATE_LSB +: 4];
    wire [2:0] rms_code = rate_r[dpb_pkg::RMS_LSB +: 3];
    wire out_rms = route_r[dpb_pkg::B_OUT_RMS];
    dpb_pkg::dpb_mode_t mode;
    assign mode = dpb_pkg::dpb_mode_t'(ctrl_r[dpb_pkg::C_MODE_LSB +: 2]);
    assign raw[0] = accel_x;
    assign raw[1] = accel_y;
    assign raw[2] = accel_z;

    // One-pole low-pass step, gain k/128
    function automatic logic signed [15:0] dpb_lp(input logic signed [15:0] x, y, input logic [6:0] k);
        logic signed [24:0] d;
        d = (25'(x) - 25'(y)) * $signed({18'h0, k});
        return 16'(25'(y) + (d >>> 7));
    endfunction

    // Byte k of a stored set; low resolution keeps the high bytes
    function automatic logic [7:0] dpb_byte(input logic [47:0] e, input logic hi, input logic [2:0] k);
        logic [15:0] w;
        w = e[47 - 16 * (hi ? k / 2 : k) -: 16];
        return hi ? (k[0] ? w[15:8] : w[7:0]) : w[15:8];
    endfunction

    // Ring pointer step
    function automatic logic [7:0] dpb_inc(input logic [7:0] p);
        return (p == 8'(DEPTH - 1)) ? 8'h00 : p + 8'h01;
    endfunction

    // APB decode, registered answer costs one wait state
    wire [7:0] idx = paddr[9:2];
    wire addr_ok = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0);
    wire apb_done = psel & penable & pready;
    wire wr_done = apb_done & pwrite & addr_ok;
    wire flush = wr_done && (idx == dpb_pkg::IDX_FLUSH);
    wire rd_pop_byte = apb_done & ~pwrite & addr_ok & (idx == dpb_pkg::IDX_OUT);
    wire [2:0] set_bytes = res_hi ? dpb_pkg::BYTES_HI : dpb_pkg::BYTES_LO;
    wire [7:0] set_limit = res_hi ? dpb_pkg::SETS_HI : dpb_pkg::SETS_LO;
    wire [10:0] lvl_wide = 11'(cnt_r) * 11'(set_bytes) - 11'(bidx_r);
    wire [9:0] level = lvl_wide[9:0];
    logic [31:0] rd_mux;
    logic mapped;

    // Read mux and map check
    always_comb begin
        rd_mux = 32'h0;
        mapped = addr_ok;
        unique case (idx)
            dpb_pkg::IDX_OUT: rd_mux = (cnt_r != 8'h0) ? {24'h0, dpb_byte(mem_r[rd_r], res_hi, bidx_r)} : 32'h0;
            dpb_pkg::IDX_FLUSH: rd_mux = 32'h0;
            dpb_pkg::IDX_RATE: rd_mux = {24'h0, rate_r};
            dpb_pkg::IDX_ROUTE: rd_mux = {24'h0, route_r};
            dpb_pkg::IDX_INVA: rd_mux = {24'h0, inva_r};
            dpb_pkg::IDX_RLOW: rd_mux = {24'h0, rlow_r};
            dpb_pkg::IDX_RMID: rd_mux = {24'h0, rmid_r};
            dpb_pkg::IDX_RHIGH: rd_mux = {24'h0, rhigh_r};
            dpb_pkg::IDX_CTRL: rd_mux = {24'h0, ctrl_r};
            dpb_pkg::IDX_STAT: rd_mux = {16'h0, trig_r, full_flag_r, wm_flag_r, 3'h0, level};
            default: mapped = 1'b0;
        endcase
    end

    // APB handshake; answer latched in the wait cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            if (psel & penable & ~pready) begin
                prdata <= pwrite ? 32'h0 : rd_mux;
                pslverr <= ~mapped;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Register writes, accepted at any time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rate_r <= dpb_pkg::REG_RESET;
            route_r <= dpb_pkg::ROUTE_RESET;
            inva_r <= dpb_pkg::REG_RESET;
            rlow_r <= dpb_pkg::REG_RESET;
            rmid_r <= dpb_pkg::REG_RESET;
            rhigh_r <= dpb_pkg::REG_RESET;
            ctrl_r <= dpb_pkg::REG_RESET;
        end else if (wr_done) begin
            unique case (idx)
                dpb_pkg::IDX_RATE: rate_r <= pwdata[7:0];
                dpb_pkg::IDX_ROUTE: route_r <= pwdata[7:0] & dpb_pkg::ROUTE_WMASK;
                dpb_pkg::IDX_INVA: inva_r <= pwdata[7:0] & dpb_pkg::TOP0_WMASK;
                dpb_pkg::IDX_RLOW: rlow_r <= pwdata[7:0];
                dpb_pkg::IDX_RMID: rmid_r <= pwdata[7:0];
                dpb_pkg::IDX_RHIGH: rhigh_r <= pwdata[7:0] & dpb_pkg::TOP0_WMASK;
                dpb_pkg::IDX_CTRL: ctrl_r <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Input averaging over 2^code raw samples
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lpcnt_r <= 8'h0;
            for (int a = 0; a < 3; a++) begin
                lpacc_r[a] <= 24'sh0;
                avg_r[a] <= 16'sh0;
            end
        end else if (accel_valid) begin
            if (lpcnt_r == 8'((9'h1 << lpavg) - 9'h1)) begin
                lpcnt_r <= 8'h0;
                for (int a = 0; a < 3; a++) begin
                    lpacc_r[a] <= 24'sh0;
                    avg_r[a] <= 16'((lpacc_r[a] + 24'(raw[a])) >>> lpavg);
                end
            end else begin
                lpcnt_r <= lpcnt_r + 8'h1;
                for (int a = 0; a < 3; a++) begin
                    lpacc_r[a] <= lpacc_r[a] + 24'(raw[a]);
                end
            end
        end
    end

    // Path rate tick; compare tolerates a live rate change
    wire [25:0] period = 26'(BASE_CYCLES >> rate_code);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ratecnt_r <= 26'h0;
            tick_r <= 1'b0;
        end else if (!eng_run) begin
            ratecnt_r <= 26'h0;
            tick_r <= 1'b0;
        end else begin
            // rate doubles per code
            // Period 0 at the top codes means a tick every cycle
            tick_r <= (ratecnt_r + 26'h1 >= period);
            ratecnt_r <= (ratecnt_r + 26'h1 >= period) ? 26'h0 : ratecnt_r + 26'h1;
        end
    end

    // Filter stages, combinational from held input
    logic signed [15:0] f1_out [3], f2_lp [3], f2_out [3];
    always_comb begin
        for (int a = 0; a < 3; a++) begin
            f1_out[a] = route_r[dpb_pkg::B_F1_BYP] ? avg_r[a] : dpb_lp(avg_r[a], y1_r[a], inva_r[6:0]);
            f2_lp[a] = dpb_lp(f1_out[a], y2_r[a], dpb_pkg::F2_COEF);
            f2_out[a] = route_r[dpb_pkg::B_F2_BYP] ? f1_out[a] :
                (route_r[dpb_pkg::B_F2_HP] ? f1_out[a] - f2_lp[a] : f2_lp[a]);
        end
    end

    // Filter state, stepped at the path rate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filt_v_r <= 1'b0;
            for (int a = 0; a < 3; a++) begin
                y1_r[a] <= 16'sh0;
                y2_r[a] <= 16'sh0;
                filt_r[a] <= 16'sh0;
            end
        end else begin
            filt_v_r <= tick_r;
            if (tick_r) begin
                for (int a = 0; a < 3; a++) begin
                    y1_r[a] <= f1_out[a];
                    y2_r[a] <= f2_lp[a];
                    filt_r[a] <= f2_out[a];
                end
            end
        end
    end

    // RMS stage: mean magnitude, cheaper than a square root
    wire [8:0] rms_n = 9'h2 << rms_code;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rmscnt_r <= 9'h0;
            rms_v_r <= 1'b0;
            for (int a = 0; a < 3; a++) begin
                rmsacc_r[a] <= 24'h0;
                rms_r[a] <= 16'h0;
            end
        end else begin
            rms_v_r <= 1'b0;
            if (!eng_run) begin
                rmscnt_r <= 9'h0;
                for (int a = 0; a < 3; a++) begin
                    rmsacc_r[a] <= 24'h0;
                end
            end else if (filt_v_r) begin
                if (rmscnt_r >= rms_n - 9'h1) begin
                    rmscnt_r <= 9'h0;
                    rms_v_r <= 1'b1;
                    for (int a = 0; a < 3; a++) begin
                        rmsacc_r[a] <= 24'h0;
                        rms_r[a] <= 16'((rmsacc_r[a] + 24'(filt_r[a][15] ? -filt_r[a] : filt_r[a])) >>
                            (4'(rms_code) + 4'h1));
                    end
                end else begin
                    rmscnt_r <= rmscnt_r + 9'h1;
                    for (int a = 0; a < 3; a++) begin
                        rmsacc_r[a] <= rmsacc_r[a] + 24'(filt_r[a][15] ? -filt_r[a] : filt_r[a]);
                    end
                end
            end
        end
    end

    // Path output registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            path_out_valid <= 1'b0;
            path_x_output <= 16'sh0;
            path_y_output <= 16'sh0;
            path_z_output <= 16'sh0;
        end else begin
            path_out_valid <= out_rms ? rms_v_r : filt_v_r;
            if (out_rms ? rms_v_r : filt_v_r) begin
                path_x_output <= out_rms ? 16'(rms_r[0]) : filt_r[0];
                path_y_output <= out_rms ? 16'(rms_r[1]) : filt_r[1];
                path_z_output <= out_rms ? 16'(rms_r[2]) : filt_r[2];
            end
        end
    end

    // Motion engine feed and its rate fields
    wire mot_path = route_r[dpb_pkg::B_MOT_IN];
    wire mot_rms = route_r[dpb_pkg::B_MOT_RMS];
    wire mot_ev = mot_path ? (mot_rms ? rms_v_r : filt_v_r) : accel_valid;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            motion_valid <= 1'b0;
            motion_x <= 16'sh0;
            motion_y <= 16'sh0;
            motion_z <= 16'sh0;
            wake_rate_used <= 4'h0;
            sleep_rate_used <= 4'h0;
            motion_avg_count <= 3'h0;
        end else begin
            motion_valid <= mot_ev;
            if (mot_ev) begin
                motion_x <= mot_path ? (mot_rms ? 16'(rms_r[0]) : filt_r[0]) : raw[0];
                motion_y <= mot_path ? (mot_rms ? 16'(rms_r[1]) : filt_r[1]) : raw[1];
                motion_z <= mot_path ? (mot_rms ? 16'(rms_r[2]) : filt_r[2]) : raw[2];
            end
            wake_rate_used <= mot_path ? rate_code : {1'b0, wake_rate_field};
            sleep_rate_used <= mot_path ? rate_code : {1'b0, sleep_rate_field};
            motion_avg_count <= mot_path ? rms_code : 3'h0;
        end
    end

    // Buffer push source and acceptance
    wire buf_path = route_r[dpb_pkg::B_BUF_SRC];
    wire push_req = ctrl_r[dpb_pkg::C_OPER] & (buf_path ? (out_rms ? rms_v_r : filt_v_r) : accel_valid);
    wire [47:0] push_data = buf_path ?
        (out_rms ? {rms_r[0], rms_r[1], rms_r[2]} : {filt_r[0], filt_r[1], filt_r[2]}) :
        {raw[0], raw[1], raw[2]};
    wire full = cnt_r >= set_limit;
    wire pop = rd_pop_byte && (cnt_r != 8'h0) && (bidx_r == set_bytes - 3'h1);
    wire accept = push_req && (mode != dpb_pkg::BUF_BYPASS) &&
        (!full || pop || mode == dpb_pkg::BUF_STREAM || (mode == dpb_pkg::BUF_TRIGGER && !trig_r));
    wire overwrite = accept && full && !pop;

    // Buffer storage; a flush wins over a push or read in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_r <= 8'h0;
            rd_r <= 8'h0;
            cnt_r <= 8'h0;
            bidx_r <= 3'h0;
        end else if (flush || !ctrl_r[dpb_pkg::C_OPER] || mode == dpb_pkg::BUF_BYPASS) begin
            wr_r <= 8'h0;
            rd_r <= 8'h0;
            cnt_r <= 8'h0;
            bidx_r <= 3'h0;
        end else begin
            if (accept) begin
                wr_r <= dpb_inc(wr_r);
            end
            if (pop || overwrite) begin
                rd_r <= dpb_inc(rd_r);
                bidx_r <= 3'h0;
            end else if (rd_pop_byte && cnt_r != 8'h0) begin
                bidx_r <= bidx_r + 3'h1;
            end
            cnt_r <= cnt_r + 8'(accept && !overwrite) - 8'(pop);
        end
    end

    // Set storage, write only
    always_ff @(posedge clk) begin
        if (accept) begin
            mem_r[wr_r] <= push_data;
        end
    end

    // Latched status and pin; trigger set wins over flush
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_r <= 1'b0;
            full_flag_r <= 1'b0;
            wm_flag_r <= 1'b0;
            irq_pin <= 1'b0;
        end else if (flush) begin
            trig_r <= trigger_event && mode == dpb_pkg::BUF_TRIGGER;
            full_flag_r <= 1'b0;
            wm_flag_r <= 1'b0;
            irq_pin <= 1'b0;
        end else begin
            trig_r <= trig_r | (trigger_event && mode == dpb_pkg::BUF_TRIGGER);
            full_flag_r <= full_flag_r | full;
            wm_flag_r <= wm_flag_r | (cnt_r >= 8'(WMARK));
            irq_pin <= irq_pin | full | (cnt_r >= 8'(WMARK));
        end
    end

    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [8:0] hlp_n;
    logic hlp_chg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hlp_n <= 9'h0;
            hlp_chg <= 1'b1;
        end else begin
            hlp_n <= rms_v_r ? 9'(filt_v_r) : hlp_n + 9'(filt_v_r);
            hlp_chg <= rms_v_r ? 1'b0 : (hlp_chg | wr_done | !eng_run);
        end
    end
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    sequence s_flush;
        flush;
    endsequence
    a_flush_empty: assert property (s_flush |=> level == 10'h0 && cnt_r == 8'h0)
        else $error("flush left data");
    a_trig_clear: assert property (flush && !trigger_event |=> !trig_r)
        else $error("trigger flag survived flush");
    a_flag_pin: assert property (s_flush |=> !full_flag_r && !wm_flag_r && !irq_pin)
        else $error("flags or pin survived flush");
    a_live_write: assert property (wr_done && idx == dpb_pkg::IDX_ROUTE
        |=> route_r == (($past(pwdata) & 32'h0000_00FB) & 32'hFF))
        else $error("live route write lost");
    a_apb_wait: assert property (s_wait |=> pready ##1 !pready)
        else $error("answer timing wrong");
    a_engine_off: assert property (!eng_run |=> !tick_r ##1 !filt_v_r)
        else $error("filters ran while disabled");
    a_rms_span: assert property (rms_v_r && !hlp_chg |-> hlp_n == (9'h2 << $past(rms_code)))
        else $error("wrong RMS span");
    a_path_src: assert property (path_out_valid && !$past(out_rms)
        |-> path_x_output == $past(filt_r[0]))
        else $error("path output not filter data");
    a_bypass_both: assert property (route_r[4] && route_r[3] |-> f2_out[0] == avg_r[0])
        else $error("bypass not transparent");
    a_motion_rate: assert property (mot_path |=> wake_rate_used == $past(rate_code))
        else $error("motion rate not path rate");
    a_buf_raw: assert property (accept && !buf_path |=> mem_r[$past(wr_r)][47:32] == $past(accel_x))
        else $error("raw data not buffered");
endmodule

// >>> testbench/dpb_host_model.sv
/*
 Host model: an APB master that reaches the block's registers.
 Assumes the bench calls one task at a time, from just after a rising edge.
*/
`timescale 1ns/10ps
module dpb_host_model (
    // Clock
    input wire logic clk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // One transfer; waits for pready, the bench watchdog guards a dead slave
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {22'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data shows junk, not the last value
        pwdata <= ~pwdata;
        // Idle edge so the next call never reassigns in this time step
        @(posedge clk);
    endtask

    task automatic set_rate(input logic [7:0] v);
        logic [31:0] old;
        logic e;
        xfer(1'b0, dpb_pkg::IDX_RATE, 8'h00, old, e);
        xfer(1'b1, dpb_pkg::IDX_RATE, {old[7], v[6:0]}, old, e);
    endtask
endmodule

// >>> testbench/dpb_tb_top.sv
/*
 Bench top: clock, reset, host model and scenarios for the path block.
 Assumes a short rate period and a watermark of two sets.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
module dpb_tb_top;
    logic clk = 1'b0; // 40 MHz
    logic rst = 1'b1; // Held 8 cycles
    logic psel, penable, pwrite, pready, pslverr, irq, e;
    logic [31:0] paddr, pwdata, prdata, d;
    logic acc_v = 1'b0; // Raw sample strobe
    logic trig = 1'b0; // Trigger pulse
    logic signed [15:0] ax = '0, ay = '0, az = '0;
    logic [3:0] wru, sru;
    logic signed [15:0] pox, mx; // Path and motion x outputs
    logic [2:0] mac;
    int fail_count = 0;
    int n_compared = 0;
    always #12.5 clk = ~clk;
    dpb_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
    dpb_top #(.WMARK(2), .BASE_CYCLES(64)) DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .accel_valid(acc_v), .accel_x(ax), .accel_y(ay), .accel_z(az),
        .trigger_event(trig), .wake_rate_field(3'h3), .sleep_rate_field(3'h1), .path_out_valid(),
        .path_x_output(pox), .path_y_output(), .path_z_output(), .motion_valid(), .motion_x(mx),
        .motion_y(), .motion_z(), .wake_rate_used(wru), .sleep_rate_used(sru), .motion_avg_count(mac),
        .irq_pin(irq));
    // Register access helpers
    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        host.xfer(1'b1, i, v, d, e);
    endtask
    task automatic rdc(input logic [7:0] i, input logic [31:0] w);
        host.xfer(1'b0, i, 8'h00, d, e);
        `CHK(d, w)
    endtask
    // One raw sample; y and z derived from x
    task automatic push(input logic [15:0] x);
        ax <= x;
        ay <= x + 16'h1111;
        az <= ~x;
        acc_v <= 1'b1;
        @(posedge clk);
        acc_v <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // Reset values, fixed-zero bits, unmapped access
    task automatic t_regs();
        rdc(dpb_pkg::IDX_ROUTE, 32'h2);
        wr(dpb_pkg::IDX_INVA, 8'hFF);
        rdc(dpb_pkg::IDX_INVA, 32'h7F);
        rdc(dpb_pkg::IDX_RHIGH, 32'h0);
        wr(dpb_pkg::IDX_RHIGH, 8'hFF);
        rdc(dpb_pkg::IDX_RHIGH, 32'h7F);
        host.xfer(1'b0, 8'h10, 8'h00, d, e);
        `CHK(e, 1'b1)
    endtask
    // Fill, read a set, flush, high resolution, trigger flag
    task automatic t_buf();
        wr(dpb_pkg::IDX_CTRL, 8'h02);
        repeat (3) push(16'h1234);
        rdc(dpb_pkg::IDX_STAT, 32'h2009);
        `CHK(irq, 1'b1)
        rdc(dpb_pkg::IDX_OUT, 32'h12);
        rdc(dpb_pkg::IDX_OUT, 32'h23);
        rdc(dpb_pkg::IDX_OUT, 32'hED);
        wr(dpb_pkg::IDX_FLUSH, 8'h5A);
        rdc(dpb_pkg::IDX_STAT, 32'h0);
        `CHK(irq, 1'b0)
        rdc(dpb_pkg::IDX_OUT, 32'h0);
        wr(dpb_pkg::IDX_CTRL, 8'h06);
        push(16'h1234);
        rdc(dpb_pkg::IDX_STAT, 32'h6);
        // whole set read back to back
        for (int k = 0; k < 6; k++) rdc(dpb_pkg::IDX_OUT, {24'h0, 8'(48'hEDCB23451234 >> (8 * k))});
        wr(dpb_pkg::IDX_CTRL, 8'h12);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        rdc(dpb_pkg::IDX_STAT, 32'h8000);
        wr(dpb_pkg::IDX_FLUSH, 8'h00);
        rdc(dpb_pkg::IDX_STAT, 32'h0);
    endtask
    // Motion engine rate and count follow routing bit 6
    task automatic t_motion();
        host.set_rate(8'h35);
        wr(dpb_pkg::IDX_ROUTE, 8'h40);
        repeat (2) @(posedge clk);
        `CHK(wru, 4'h5)
        `CHK(mac, 3'h3)
        `CHK(sru, 4'h5)
        wr(dpb_pkg::IDX_ROUTE, 8'h00);
        repeat (2) @(posedge clk);
        `CHK(wru, 4'h3)
        `CHK(sru, 4'h1)
    endtask
    // Engine on, both filters bypassed: outputs follow the new sample
    task automatic t_path();
        wr(dpb_pkg::IDX_ROUTE, 8'h58);
        wr(dpb_pkg::IDX_CTRL, 8'h03);
        push(16'h0123);
        repeat (8) @(posedge clk);
        `CHK(pox, 16'h0123)
        `CHK(mx, 16'h0123)
    endtask
    // Verdict and end of run
    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog, well past the expected run of under two hundred cycles
    initial begin
        #200000;
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_buf();
        t_motion();
        t_path();
        complete_run();
    end
endmodule
